// ===== logic/avg_settle.sv
// exponential data average with a power-of-two time constant
// assumes sample_i is a one-cycle pulse on the same clock
`timescale 1ns/100ps
`default_nettype none
module avg_settle (
   // clock, reset, enable
   input  wire logic                              ref_clk_i,
   input  wire logic                              rst_n_i,
   input  wire logic                              ce_i,
   // new conversion result
   input  wire logic                              sample_i,
   input  wire logic [prox_cfg_pkg::DATA_W-1:0]   data_i,
   input  wire logic [3:0]                        settle_i,
   // averaged value
   output logic      [prox_cfg_pkg::DATA_W-1:0]   avg_o
);

   localparam int ACC_W = prox_cfg_pkg::DATA_W + prox_cfg_pkg::FRAC_W;

   logic        [ACC_W-1:0] acc_ff;
   logic        [ACC_W-1:0] nxt_acc;
   logic signed [ACC_W:0]   diff;
   logic signed [ACC_W:0]   step;
   logic        [4:0]       shift;

   assign shift = {1'b0, settle_i} + 5'h01;

   always_comb begin
      diff    = $signed({1'b0, data_i, {prox_cfg_pkg::FRAC_W{1'b0}}}) - $signed({1'b0, acc_ff});
      step    = diff >>> shift;
      nxt_acc = acc_ff;
      if (sample_i) begin
         nxt_acc = acc_ff + step[ACC_W-1:0];
      end
   end

   // accumulator register
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         acc_ff <= '0;
      end else if (ce_i) begin
         acc_ff <= nxt_acc;
      end
   end

   assign avg_o = acc_ff[ACC_W-1:prox_cfg_pkg::FRAC_W];

endmodule
`default_nettype wire

// ===== logic/prox_cfg_pkg.sv
// constants shared by the proximity threshold configuration block
// assumes one core clock; register pointer values as seen by the serial port
package prox_cfg_pkg;

   // register pointers and preset values
   localparam logic [7:0] ADDR_SETUP   = 8'h0b;
   localparam logic [7:0] ADDR_CONFIG  = 8'h0f;
   localparam logic [7:0] SETUP_RESET  = 8'h0b;
   localparam logic [7:0] CONFIG_RESET = 8'h19;
   localparam logic [7:0] RDATA_NONE   = 8'h00;

   // setup register fields
   localparam int SPAN_HI_BIT   = 7;
   localparam int SPAN_LO_BIT   = 6;
   localparam int HYST_DIS_BIT  = 4;
   localparam int SETTLE_MSB    = 3;
   localparam int SETTLE_LSB    = 0;

   // configuration register fields
   localparam int FIXED_BIT     = 7;
   localparam int CMP_HI_BIT    = 6;
   localparam int CMP_LO_BIT    = 5;
   localparam int CONV_EN_BIT   = 4;
   localparam int OPMODE_MSB    = 2;
   localparam int OPMODE_LSB    = 0;

   // data widths
   localparam int DATA_W        = 12;
   localparam int SENS_W        = 8;
   localparam int FRAC_W        = 16;
   localparam int HYST_SHIFT    = 2;

   // input span in femtofarads per span code
   localparam logic [12:0] SPAN_FF_00 = 13'h07d0;
   localparam logic [12:0] SPAN_FF_01 = 13'h01f4;
   localparam logic [12:0] SPAN_FF_10 = 13'h03e8;
   localparam logic [12:0] SPAN_FF_11 = 13'h0fa0;

   // automatic offset adjust step in offset dac lsbs per span code
   localparam logic [3:0] DAC_STEP_00 = 4'h4;
   localparam logic [3:0] DAC_STEP_01 = 4'h1;
   localparam logic [3:0] DAC_STEP_10 = 4'h2;
   localparam logic [3:0] DAC_STEP_11 = 4'h8;

   // output comparator modes
   typedef enum logic [1:0] {
      CMP_NEG    = 2'h0,
      CMP_POS    = 2'h1,
      CMP_INWIN  = 2'h2,
      CMP_OUTWIN = 2'h3
   } cmp_mode_e;

endpackage

// ===== logic/proximity_threshold_config.sv
// setup and configuration registers of the proximity converter, with
// the span/step decode, data average and output comparator they steer
// assumes the serial port presents a pointer, write strobe and data on this clock
`timescale 1ns/100ps
`default_nettype none
module proximity_threshold_config (
   // clock, reset, enable
   input  wire logic                              ref_clk_i,
   input  wire logic                              rst_n_i,
   input  wire logic                              ce_i,
   // register access from the serial port pointer
   input  wire logic [7:0]                        reg_addr_i,
   input  wire logic                              reg_wr_i,
   input  wire logic [7:0]                        reg_wdata_i,
   output logic      [7:0]                        reg_rdata_o,
   // conversion results and threshold values
   input  wire logic                              conv_done_i,
   input  wire logic [prox_cfg_pkg::DATA_W-1:0]   conv_data_i,
   input  wire logic [prox_cfg_pkg::SENS_W-1:0]   sensitivity_i,
   input  wire logic [prox_cfg_pkg::DATA_W-1:0]   fixed_threshold_i,
   // decoded settings
   output logic      [1:0]                        span_select_o,
   output logic      [12:0]                       span_ff_o,
   output logic      [3:0]                        dac_step_o,
   output logic                                   hyst_active_o,
   output logic                                   conversion_enable_o,
   output logic      [2:0]                        operating_mode_o,
   // average and detection
   output logic      [prox_cfg_pkg::DATA_W-1:0]   average_o,
   output logic                                   out_flag_o
);

   localparam int CW = prox_cfg_pkg::DATA_W + 2;

   // register state
   logic [7:0]                      setup_ff;
   logic [7:0]                      nxt_setup;
   logic [7:0]                      config_ff;
   logic [7:0]                      nxt_config;
   logic [7:0]                      rdata_ff;
   logic [7:0]                      nxt_rdata;

   // decoded output state
   logic [1:0]                      span_ff;
   logic [12:0]                     span_ff_ff;
   logic [12:0]                     nxt_span_ff;
   logic [3:0]                      step_ff;
   logic [3:0]                      nxt_step;
   logic                            hyst_ff;
   logic                            nxt_hyst;
   logic                            out_ff;
   logic                            nxt_out;
   logic [prox_cfg_pkg::DATA_W-1:0] avg_q;
   logic [prox_cfg_pkg::DATA_W-1:0] avg_ff;

   // field views
   logic [1:0]                      span_sel;
   logic                            fixed_sel;
   prox_cfg_pkg::cmp_mode_e         cmp_mode;

   // decode span code to femtofarads
   function automatic logic [12:0] span_to_ff(input logic [1:0] code);
      case (code)
         2'h0:    span_to_ff = prox_cfg_pkg::SPAN_FF_00;
         2'h1:    span_to_ff = prox_cfg_pkg::SPAN_FF_01;
         2'h2:    span_to_ff = prox_cfg_pkg::SPAN_FF_10;
         default: span_to_ff = prox_cfg_pkg::SPAN_FF_11;
      endcase
   endfunction

   // decode span code to offset dac step
   function automatic logic [3:0] span_to_step(input logic [1:0] code);
      case (code)
         2'h0:    span_to_step = prox_cfg_pkg::DAC_STEP_00;
         2'h1:    span_to_step = prox_cfg_pkg::DAC_STEP_01;
         2'h2:    span_to_step = prox_cfg_pkg::DAC_STEP_10;
         default: span_to_step = prox_cfg_pkg::DAC_STEP_11;
      endcase
   endfunction

   assign span_sel  = {setup_ff[prox_cfg_pkg::SPAN_HI_BIT], setup_ff[prox_cfg_pkg::SPAN_LO_BIT]};
   assign fixed_sel = config_ff[prox_cfg_pkg::FIXED_BIT];
   assign cmp_mode  = prox_cfg_pkg::cmp_mode_e'({config_ff[prox_cfg_pkg::CMP_HI_BIT],
                                                  config_ff[prox_cfg_pkg::CMP_LO_BIT]});

   // register writes and read data
   always_comb begin
      nxt_setup  = setup_ff;
      nxt_config = config_ff;
      if (reg_wr_i && reg_addr_i == prox_cfg_pkg::ADDR_SETUP) begin
         nxt_setup = reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == prox_cfg_pkg::ADDR_CONFIG) begin
         nxt_config = reg_wdata_i;
      end
      case (reg_addr_i)
         prox_cfg_pkg::ADDR_SETUP:  nxt_rdata = setup_ff;
         prox_cfg_pkg::ADDR_CONFIG: nxt_rdata = config_ff;
         default:                   nxt_rdata = prox_cfg_pkg::RDATA_NONE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         setup_ff  <= prox_cfg_pkg::SETUP_RESET;
         config_ff <= prox_cfg_pkg::CONFIG_RESET;
         rdata_ff  <= prox_cfg_pkg::RDATA_NONE;
      end else if (ce_i) begin
         setup_ff  <= nxt_setup;
         config_ff <= nxt_config;
         rdata_ff  <= nxt_rdata;
      end
   end

   // span, dac step and hysteresis decode
   always_comb begin
      nxt_span_ff = span_to_ff(span_sel);
      nxt_step    = span_to_step(span_sel);
      nxt_hyst    = !fixed_sel && !setup_ff[prox_cfg_pkg::HYST_DIS_BIT];
   end

   // decoded setting registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         span_ff    <= 2'h0;
         span_ff_ff <= prox_cfg_pkg::SPAN_FF_00;
         step_ff    <= prox_cfg_pkg::DAC_STEP_00;
         hyst_ff    <= 1'b0;
      end else if (ce_i) begin
         span_ff    <= span_sel;
         span_ff_ff <= nxt_span_ff;
         step_ff    <= nxt_step;
         hyst_ff    <= nxt_hyst;
      end
   end

   avg_settle u_avg (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .sample_i  (conv_done_i),
      .data_i    (conv_data_i),
      .settle_i  (setup_ff[prox_cfg_pkg::SETTLE_MSB:prox_cfg_pkg::SETTLE_LSB]),
      .avg_o     (avg_q)
   );

   // comparator thresholds, signed and wide so nothing wraps
   logic signed [CW-1:0] data_s;
   logic signed [CW-1:0] hi_thr;
   logic signed [CW-1:0] lo_thr;
   logic signed [CW-1:0] hyst_amt;
   logic signed [CW-1:0] sens_s;

   assign data_s   = $signed({2'b00, conv_data_i});
   assign sens_s   = $signed({{(CW-prox_cfg_pkg::SENS_W){1'b0}}, sensitivity_i});
   assign hyst_amt = (hyst_ff && out_ff) ? (sens_s >>> prox_cfg_pkg::HYST_SHIFT) : '0;

   // output comparator, evaluated on each finished conversion
   always_comb begin
      if (fixed_sel) begin
         hi_thr = $signed({2'b00, fixed_threshold_i});
         lo_thr = $signed({2'b00, fixed_threshold_i});
      end else begin
         hi_thr = $signed({2'b00, avg_q}) + sens_s;
         lo_thr = $signed({2'b00, avg_q}) - sens_s;
      end
      nxt_out = out_ff;
      if (conv_done_i) begin
         // once active, release needs the hysteresis margin in adaptive mode with the disable bit clear; in fixed mode it never applies
         case (cmp_mode)
            prox_cfg_pkg::CMP_NEG:    nxt_out = data_s < lo_thr + hyst_amt;
            prox_cfg_pkg::CMP_POS:    nxt_out = data_s > hi_thr - hyst_amt;
            prox_cfg_pkg::CMP_INWIN:  nxt_out = !fixed_sel && data_s > lo_thr - hyst_amt
                                                && data_s < hi_thr + hyst_amt;
            prox_cfg_pkg::CMP_OUTWIN: nxt_out = !fixed_sel && (data_s < lo_thr + hyst_amt
                                                || data_s > hi_thr - hyst_amt);
            default:                  nxt_out = 1'b0;
         endcase
      end
   end

   // flag and average output registers
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         out_ff <= 1'b0;
         avg_ff <= '0;
      end else if (ce_i) begin
         out_ff <= nxt_out;
         avg_ff <= avg_q;
      end
   end

   assign reg_rdata_o         = rdata_ff;
   assign span_select_o       = span_ff;
   assign span_ff_o           = span_ff_ff;
   assign dac_step_o          = step_ff;
   assign hyst_active_o       = hyst_ff;
   assign conversion_enable_o = config_ff[prox_cfg_pkg::CONV_EN_BIT];
   assign operating_mode_o    = config_ff[prox_cfg_pkg::OPMODE_MSB:prox_cfg_pkg::OPMODE_LSB];
   assign average_o           = avg_ff;
   assign out_flag_o          = out_ff;

endmodule
`default_nettype wire

// ===== sim/prox_cfg_chk.sv
// checker for the setup and configuration registers
// assumes bind onto proximity_threshold_config, one clock
`timescale 1ns/100ps
`default_nettype none
module prox_cfg_chk (
   // clock, reset, enable
   input wire logic                            ref_clk_i,
   input wire logic                            rst_n_i,
   input wire logic                            ce_i,
   // register port
   input wire logic [7:0]                      reg_addr_i,
   input wire logic                            reg_wr_i,
   input wire logic [7:0]                      reg_wdata_i,
   input wire logic [7:0]                      reg_rdata_o,
   input wire logic                            conv_done_i,
   // decoded settings and results
   input wire logic [1:0]                      span_select_o,
   input wire logic [12:0]                     span_ff_o,
   input wire logic [3:0]                      dac_step_o,
   input wire logic                            hyst_active_o,
   input wire logic                            conversion_enable_o,
   input wire logic [2:0]                      operating_mode_o,
   input wire logic [prox_cfg_pkg::DATA_W-1:0] average_o,
   input wire logic                            out_flag_o
);
   logic [16:0] exp_dec;
   logic        taken;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // expected span and step for the span code
   always_comb begin
      case (span_select_o)
         2'h0:    exp_dec = {13'h07d0, 4'h4};
         2'h1:    exp_dec = {13'h01f4, 4'h1};
         2'h2:    exp_dec = {13'h03e8, 4'h2};
         default: exp_dec = {13'h0fa0, 4'h8};
      endcase
   end
   assign taken = ce_i && conv_done_i;
   chk_span_decode: assert property (span_ff_o == exp_dec[16:4])
      else $error("span value does not match span code");
   chk_dac_step: assert property (dac_step_o == exp_dec[3:0])
      else $error("offset step does not match span code");
   chk_hyst_disable: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h0b && reg_wdata_i[4] ##1 ce_i
      |=> !hyst_active_o) else $error("hysteresis still active after disable");
   chk_fixed_nohyst: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h0f && reg_wdata_i[7] ##1 ce_i
      |=> !hyst_active_o) else $error("hysteresis active in fixed mode");
   chk_wr_readback: assert property ((ce_i && reg_wr_i && (reg_addr_i == 8'h0b || reg_addr_i == 8'h0f))
      ##1 (ce_i && !reg_wr_i && $stable(reg_addr_i)) |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("written byte not read back");
   chk_unmapped_zero: assert property (ce_i && reg_addr_i != 8'h0b && reg_addr_i != 8'h0f
      |=> reg_rdata_o == 8'h00) else $error("unmapped pointer reads nonzero");
   chk_cfg_mirror: assert property (ce_i && reg_wr_i && reg_addr_i == 8'h0f
      |=> {3'h0, conversion_enable_o, 1'b0, operating_mode_o} == ($past(reg_wdata_i) & 8'h17))
      else $error("mode outputs differ from written byte");
   chk_reset_values: assert property (disable iff (1'b0) !rst_n_i && ce_i
      |=> conversion_enable_o && operating_mode_o == 3'h1 && span_ff_o == 13'h07d0)
      else $error("preset outputs wrong after reset");
   chk_flag_hold: assert property (!taken |=> $stable(out_flag_o))
      else $error("flag moved without a conversion");
   chk_avg_hold: assert property (ce_i && !conv_done_i |-> ##2 $stable(average_o))
      else $error("average moved without a conversion");
   cover property (taken ##1 out_flag_o);
   cover property (ce_i && reg_wr_i && reg_addr_i == 8'h0f);
   cover property (hyst_active_o ##1 !hyst_active_o);
endmodule
bind proximity_threshold_config prox_cfg_chk u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
   .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .conv_done_i(conv_done_i), .span_select_o(span_select_o), .span_ff_o(span_ff_o), .dac_step_o(dac_step_o),
   .hyst_active_o(hyst_active_o), .conversion_enable_o(conversion_enable_o),
   .operating_mode_o(operating_mode_o), .average_o(average_o), .out_flag_o(out_flag_o));
`default_nettype wire

// ===== sim/prox_host.sv
// host model driving the register pointer port
// assumes the core clock; outputs change on falling edges
`timescale 1ns/100ps
`default_nettype none
module prox_host (
   // clock and read data
   input  wire logic       ref_clk_i,
   input  wire logic [7:0] reg_rdata_i,
   // register requests
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o
);
   initial begin
      reg_addr_o  = 8'h00;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
   end
   // one-cycle strobe, pointer left in place
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= (a == 8'h0b) ? (d & 8'hdf) : ((a == 8'h0f) ? (d | 8'h10) : d);
      reg_wr_o    <= 1'b1;
      @(negedge ref_clk_i);
      reg_wr_o    <= 1'b0;
   endtask
   // pointer set, byte taken two edges on
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      reg_addr_o <= a;
      repeat (2) @(negedge ref_clk_i);
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// ===== sim/proximity_threshold_config_tb_top.sv
// self-checking bench for the proximity setup and configuration block
// assumes the host model and the bound checker alongside
`timescale 1ns/100ps
`default_nettype none
module proximity_threshold_config_tb_top;
   typedef struct packed {logic [7:0] wd; logic [12:0] ff; logic [3:0] st; logic hy;} row_s;
   row_s        rows [4] = '{'{8'h00, 13'h07d0, 4'h4, 1'b1}, '{8'h40, 13'h01f4, 4'h1, 1'b1},
                             '{8'h80, 13'h03e8, 4'h2, 1'b1}, '{8'hd0, 13'h0fa0, 4'h8, 1'b0}};
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr, conv = 1'b0, hyst, conv_en, flag;
   logic [7:0]  addr, wdata, rdata, r, sens = 8'h10;
   logic [11:0] cdata = 12'h000, fthr = 12'h700, avg;
   logic [12:0] span_ff;
   logic [3:0]  step;
   logic [2:0]  op_mode;
   logic [1:0]  span_sel;
   int          miscompares = 0;
   int          n_compared = 0;
   always #20 clk = ~clk;
   proximity_threshold_config u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .conv_done_i(conv), .conv_data_i(cdata),
      .sensitivity_i(sens), .fixed_threshold_i(fthr), .span_select_o(span_sel), .span_ff_o(span_ff),
      .dac_step_o(step), .hyst_active_o(hyst), .conversion_enable_o(conv_en),
      .operating_mode_o(op_mode), .average_o(avg), .out_flag_o(flag));
   prox_host u_host (.ref_clk_i(clk), .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic reset_for(input int n);
      rst_n <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic presets;
      u_host.rd_reg(8'h0b, r);
      chk(r, 8'h0b);
      u_host.rd_reg(8'h0f, r);
      chk(r, 8'h19);
      chk({conv_en, op_mode}, 4'h9);
      chk(span_ff, 13'h07d0);
      chk(step, 4'h4);
      chk(hyst, 1'b1);
      chk(avg, 12'h000);
      chk(flag, 1'b0);
   endtask
   // one conversion pulse, results settled on return
   task automatic convert(input logic [11:0] d);
      @(negedge clk);
      conv  <= 1'b1;
      cdata <= d;
      @(negedge clk);
      conv <= 1'b0;
      @(negedge clk);
   endtask
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      end_of_test();
   end
   initial begin
      reset_for(12);
      presets();
      for (int i = 0; i < 4; i++) begin
         u_host.wr_reg(8'h0b, rows[i].wd);
         u_host.rd_reg(8'h0b, r);
         chk(r, rows[i].wd);
         chk(span_ff, rows[i].ff);
         chk(span_sel, rows[i].wd[7:6]);
         chk(step, rows[i].st);
         chk(hyst, rows[i].hy);
      end
      convert(12'h800);
      chk(avg, 12'h400);
      convert(12'h800);
      chk(avg, 12'h600);
      u_host.wr_reg(8'h0f, 8'h21);
      u_host.rd_reg(8'h0f, r);
      chk(r, 8'h31);
      convert(12'h612);
      chk(flag, 1'b1);
      chk(avg, 12'h609);
      convert(12'h619);
      chk(flag, 1'b0);
      u_host.wr_reg(8'h0b, 8'h00);
      u_host.wr_reg(8'h0f, 8'hb1);
      u_host.rd_reg(8'h0f, r);
      chk(hyst, 1'b0);
      convert(12'h701);
      chk(flag, 1'b1);
      convert(12'h700);
      chk(flag, 1'b0);
      u_host.wr_reg(8'h0f, 8'h21);
      u_host.rd_reg(8'h0f, r);
      chk(hyst, 1'b1);
      // positive adaptive with hysteresis: flag holds inside the margin
      convert(12'h6e4);
      chk(flag, 1'b1);
      convert(12'h6e2);
      chk(flag, 1'b1);
      chk(avg, 12'h6db);
      // in-window adaptive
      u_host.wr_reg(8'h0f, 8'h41);
      convert(12'h7ff);
      chk(flag, 1'b0);
      convert(12'h76d);
      chk(flag, 1'b1);
      // out-of-window adaptive
      u_host.wr_reg(8'h0f, 8'h61);
      convert(12'h76d);
      chk(flag, 1'b0);
      convert(12'h790);
      chk(flag, 1'b1);
      // negative adaptive
      u_host.wr_reg(8'h0f, 8'h01);
      convert(12'h77e);
      chk(flag, 1'b0);
      convert(12'h700);
      chk(flag, 1'b1);
      chk(avg, 12'h73f);
      u_host.wr_reg(8'h0c, 8'hff);
      u_host.rd_reg(8'h0c, r);
      chk(r, 8'h00);
      ce <= 1'b0;
      u_host.wr_reg(8'h0b, 8'h40);
      ce <= 1'b1;
      u_host.rd_reg(8'h0b, r);
      chk(r, 8'h00);
      chk(span_ff, 13'h07d0);
      // settling field 1: time constant of four conversions
      u_host.wr_reg(8'h0b, 8'h01);
      convert(12'h33f);
      chk(avg, 12'h63f);
      @(negedge clk);
      reset_for(2);
      presets();
      end_of_test();
   end
endmodule
`default_nettype wire
